// ---- hdl/aodiag_record.sv ----
// Diagnostic record of a four-channel analog output module, read byte by byte.
//
// How it works
// RQ1 - Type byte reads 73h for analog output, bit 7 reserved as zero.
// RQ2 - A constant byte reports eight diagnostic bits per channel.
// RQ3 - A constant byte reports four channels in this module.
// RQ4 - Summary bits 0..3 flag faulty channel groups; bits 7..4 read zero.
// RQ5 - Detail bit 0 flags a configuration or parameter fault; bits 2..1 zero.
// RQ6 - Detail bit 3 flags an output short to ground; bits 7..4 zero.
// RQ7 - Four timestamp bytes hold the microsecond ticker at the latest fault.
// RQ8 - Short faults are reported only for channels whose detection is enabled.
// RQ9 - Each fault lights its channel indicator and is recorded; no interrupt.
// RQ10 - Each summary bit is the OR of its channel's defined detail bits.
`timescale 1ns/1ns
module aodiag_record
    import aodiag_pkg::*;
#(
    parameter int NUM_CH = NUM_CHANNELS
) (
    // Clock and reset.
    input  wire logic                   i_clock,
    input  wire logic                   i_rst_n,
    // Fault sources, one bit per channel.
    input  wire logic [NUM_CH-1:0]      i_param_fault,
    input  wire logic [NUM_CH-1:0]      i_short_detect,
    input  wire logic [NUM_CH-1:0]      i_short_enable,
    // Record read port from the head station.
    input  wire logic                   i_rd_en,
    input  wire logic [REC_IDX_W-1:0]   i_rd_index,
    output logic      [7:0]             o_rd_data,
    output logic                        o_rd_valid,
    // Channel error indicators.
    output logic      [NUM_CH-1:0]      o_channel_led
);

    logic [7:0]            tick_div;
    logic                  tick_pulse;
    logic [31:0]           us_count;
    logic [7:0]            detail      [NUM_CH];
    logic [7:0]            next_detail [NUM_CH];
    logic [NUM_CH-1:0]     group_fault;
    logic [NUM_CH-1:0]     next_group_fault;
    logic [NUM_CH-1:0]     rising_fault;
    logic                  new_fault;
    logic [31:0]           fault_capture_microseconds;
    logic [7:0]            summary_byte;
    logic [7:0]            next_rd_data;

    // Microsecond ticker divided down from the module clock.
    assign tick_pulse = (tick_div == 8'(TICK_CYCLES - 1));

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_div <= 8'h00;
        end else if (tick_pulse) begin
            tick_div <= 8'h00;
        end else begin
            tick_div <= tick_div + 8'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            us_count <= STAMP_RESET;
        end else if (tick_pulse) begin
            us_count <= us_count + 32'h0000_0001;
        end
    end

    // Per-channel detail bytes and group summary.
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
            always_comb begin
                next_detail[ch]                  = BYTE_ZERO;
                next_detail[ch][BIT_PARAM_FAULT] = i_param_fault[ch];                          // [RQ5]
                next_detail[ch][BIT_SHORT_FAULT] = i_short_detect[ch] & i_short_enable[ch];    // [RQ6] [RQ8]
                next_group_fault[ch]             = |(next_detail[ch] & DETAIL_USED_MASK);      // [RQ10]
                rising_fault[ch]                 = |(next_detail[ch] & ~detail[ch] & DETAIL_USED_MASK);
            end

            always_ff @(posedge i_clock or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    detail[ch] <= BYTE_ZERO;
                end else begin
                    detail[ch] <= next_detail[ch];
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            group_fault <= '0;
        end else begin
            group_fault <= next_group_fault;                                                  // [RQ4] [RQ10]
        end
    end

    // Indicators follow the group summary; nothing else is raised.
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_channel_led <= '0;
        end else begin
            o_channel_led <= next_group_fault;                                                // [RQ9]
        end
    end

    // A newly appearing fault bit stamps the ticker value.
    assign new_fault = |rising_fault;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fault_capture_microseconds <= STAMP_RESET;
        end else if (new_fault) begin
            fault_capture_microseconds <= us_count;                                           // [RQ7]
        end
    end

    // Read multiplexer; bytes outside this part of the record read as zero.
    always_comb begin
        summary_byte               = BYTE_ZERO;
        summary_byte[NUM_CH-1:0]   = group_fault;
        summary_byte               = summary_byte & SUMMARY_USED_MASK;                        // [RQ4]
        next_rd_data               = BYTE_ZERO;
        if (i_rd_index == IDX_KIND) begin
            next_rd_data = KIND_ANALOG_OUT & KIND_FIELD_MASK;                                 // [RQ1]
        end else if (i_rd_index == IDX_BITS) begin
            next_rd_data = DIAG_BITS_VALUE;                                                   // [RQ2]
        end else if (i_rd_index == IDX_COUNT) begin
            next_rd_data = CHAN_COUNT_VALUE;                                                  // [RQ3]
        end else if (i_rd_index == IDX_SUMMARY) begin
            next_rd_data = summary_byte;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (i_rd_index == IDX_CH0 + REC_IDX_W'(i)) begin
                next_rd_data = detail[i] & DETAIL_USED_MASK;                                  // [RQ5] [RQ6]
            end
        end
        for (int k = 0; k < STAMP_BYTES; k++) begin
            if (i_rd_index == IDX_STAMP0 + REC_IDX_W'(k)) begin
                next_rd_data = fault_capture_microseconds[8*k +: 8];                          // [RQ7]
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= BYTE_ZERO;
        end else if (i_rd_en) begin
            o_rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_valid <= 1'b0;
        end else begin
            o_rd_valid <= i_rd_en;
        end
    end

    // Checks on the record contents and their timing.
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    chk_kind_code_read: assert property ( // [RQ1]
        i_rd_en && i_rd_index == IDX_KIND |=> o_rd_valid && o_rd_data == 8'h73 && !o_rd_data[7])
        else $error("Type byte did not read as analog output.");

    chk_bit_count_read: assert property ( // [RQ2]
        i_rd_en && i_rd_index == IDX_BITS |=> o_rd_data == 8'h08)
        else $error("Diagnostic bit count byte is wrong.");

    chk_chan_count_read: assert property ( // [RQ3]
        i_rd_en && i_rd_index == IDX_COUNT |=> o_rd_data == 8'h04)
        else $error("Channel count byte is wrong.");

    chk_summary_read_rsvd: assert property ( // [RQ4]
        i_rd_en && i_rd_index == IDX_SUMMARY |=> o_rd_data[7:4] == 4'h0
            && o_rd_data[3:0] == $past(group_fault))
        else $error("Summary byte has reserved bits set or wrong groups.");

    chk_param_fault_bit: assert property ( // [RQ5]
        i_param_fault[0] |=> detail[0][0] && detail[0][2:1] == 2'b00)
        else $error("Channel 0 parameter fault not recorded.");

    chk_short_fault_bit: assert property ( // [RQ6]
        i_short_detect[1] && i_short_enable[1] |=> detail[1][3] && detail[1][7:4] == 4'h0)
        else $error("Channel 1 short fault not recorded.");

    chk_short_gated_off: assert property ( // [RQ8]
        !i_short_enable[2] |=> !detail[2][3])
        else $error("Short fault reported on a disabled channel.");

    chk_stamp_capture: assert property ( // [RQ7]
        new_fault |=> fault_capture_microseconds == $past(us_count))
        else $error("Timestamp did not capture the ticker at the fault.");

    chk_stamp_holds: assert property ( // [RQ7]
        !new_fault |=> $stable(fault_capture_microseconds))
        else $error("Timestamp changed without a new fault.");

    chk_ticker_period: assert property ( // [RQ7]
        tick_pulse |=> !tick_pulse [*8] ##92 tick_pulse)
        else $error("Microsecond ticker period is not one hundred cycles.");

    chk_led_follows: assert property ( // [RQ9]
        o_channel_led == group_fault)
        else $error("Channel indicator disagrees with group summary.");

    chk_summary_or: assert property ( // [RQ10]
        group_fault[3] == (detail[3][0] | detail[3][3]))
        else $error("Group summary is not the OR of its detail bits.");

    chk_stamp_read_lsb: assert property ( // [RQ7]
        i_rd_en && i_rd_index == IDX_STAMP0 && !new_fault |=> o_rd_data == fault_capture_microseconds[7:0])
        else $error("Timestamp low byte read back wrong.");

    chk_bits_read_valid: assert property ( // [RQ2]
        i_rd_en && i_rd_index == IDX_BITS |=> o_rd_valid)
        else $error("Diagnostic bit count read gave no valid strobe.");

    chk_count_read_valid: assert property ( // [RQ3]
        i_rd_en && i_rd_index == IDX_COUNT |=> o_rd_valid)
        else $error("Channel count read gave no valid strobe.");

    chk_summary_read_valid: assert property ( // [RQ4]
        i_rd_en && i_rd_index == IDX_SUMMARY |=> o_rd_valid)
        else $error("Summary read gave no valid strobe.");

    chk_summary_sets: assert property ( // [RQ4]
        i_short_detect[0] && i_short_enable[0] |=> group_fault[0])
        else $error("Group 0 summary missed an enabled short.");

    chk_summary_clears: assert property ( // [RQ10]
        !i_param_fault[1] && !(i_short_detect[1] && i_short_enable[1])
            |=> !group_fault[1])
        else $error("Group 1 summary set without a defined fault bit.");

    chk_summary_param: assert property ( // [RQ10]
        i_param_fault[3] |=> group_fault[3] && o_channel_led[3])
        else $error("Group 3 summary missed a parameter fault.");

    chk_detail_read_rsvd: assert property ( // [RQ5]
        i_rd_en && i_rd_index == IDX_CH0
            |=> o_rd_data[7:4] == 4'h0 && o_rd_data[2:1] == 2'b00)
        else $error("Channel 0 detail byte has reserved bits set.");

    chk_param_clears: assert property ( // [RQ5]
        !i_param_fault[0] |=> !detail[0][0])
        else $error("Channel 0 parameter fault bit stuck after its cause went.");

    chk_detail_read_value: assert property ( // [RQ6]
        i_rd_en && i_rd_index == IDX_CH0 + 5'h02
            |=> o_rd_data == $past(detail[2]))
        else $error("Channel 2 detail byte read back wrong.");

    chk_short_clears: assert property ( // [RQ6]
        !i_short_detect[1] |=> !detail[1][3])
        else $error("Channel 1 short fault bit stuck after its cause went.");

    chk_short_gated_sum: assert property ( // [RQ8]
        i_short_detect[3] && !i_short_enable[3] && !i_param_fault[3]
            |=> !group_fault[3] && !o_channel_led[3])
        else $error("Disabled short raised group 3 summary or indicator.");

    chk_led_lit_fault: assert property ( // [RQ9]
        i_param_fault[1] |=> o_channel_led[1])
        else $error("Channel 1 indicator dark during a parameter fault.");

    chk_led_dark_clean: assert property ( // [RQ9]
        !i_param_fault[2] && !(i_short_detect[2] && i_short_enable[2])
            |=> !o_channel_led[2])
        else $error("Channel 2 indicator lit without a fault.");

    chk_stamp_on_rise: assert property ( // [RQ7]
        $rose(i_param_fault[3]) |=> fault_capture_microseconds == $past(us_count))
        else $error("Timestamp not taken when channel 3 fault appeared.");

    chk_ticker_step: assert property ( // [RQ7]
        tick_pulse |=> us_count == $past(us_count) + 32'h0000_0001)
        else $error("Microsecond ticker did not advance by one.");

    chk_ticker_still: assert property ( // [RQ7]
        !tick_pulse |=> $stable(us_count))
        else $error("Microsecond ticker moved between ticks.");

    chk_stamp_read_mid: assert property ( // [RQ7]
        i_rd_en && i_rd_index == IDX_STAMP0 + 5'h01 && !new_fault
            |=> o_rd_data == fault_capture_microseconds[15:8])
        else $error("Timestamp second byte read back wrong.");

    chk_stamp_read_msb: assert property ( // [RQ7]
        i_rd_en && i_rd_index == IDX_STAMP0 + 5'h03 && !new_fault
            |=> o_rd_data == fault_capture_microseconds[31:24])
        else $error("Timestamp high byte read back wrong.");

    cov_param_fault: cover property (i_param_fault[0] ##1 detail[0][0]);
    cov_short_gated: cover property (i_short_detect[1] && !i_short_enable[1]);
    cov_stamp_read: cover property (new_fault ##[1:20] (i_rd_en && i_rd_index == IDX_STAMP0));
    cov_all_groups: cover property (&group_fault);
    cov_restamp: cover property (new_fault && |group_fault);

endmodule : aodiag_record

// ---- hdl/aodiag_pkg.sv ----
// Constants for the analog output diagnostic record.
package aodiag_pkg;

    // Microsecond ticker timing.
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Record geometry.
    localparam int NUM_CHANNELS   = 4;
    localparam int REC_IDX_W      = 5;
    localparam int STAMP_BYTES    = 4;
    localparam int SPARE_BYTES    = 4;

    // Byte indices within the diagnostic record.
    localparam logic [REC_IDX_W-1:0] IDX_KIND     = 5'h04;
    localparam logic [REC_IDX_W-1:0] IDX_BITS     = 5'h05;
    localparam logic [REC_IDX_W-1:0] IDX_COUNT    = 5'h06;
    localparam logic [REC_IDX_W-1:0] IDX_SUMMARY  = 5'h07;
    localparam logic [REC_IDX_W-1:0] IDX_CH0      = 5'h08;
    localparam logic [REC_IDX_W-1:0] IDX_SPARE0   = 5'h0C;
    localparam logic [REC_IDX_W-1:0] IDX_STAMP0   = 5'h10;

    // Constant record contents.
    localparam logic [7:0] KIND_FIELD_MASK   = 8'h7F;
    localparam logic [7:0] KIND_DIG_IN       = 8'h70;
    localparam logic [7:0] KIND_ANALOG_OUT   = 8'h73;
    localparam logic [7:0] KIND_COUNTER      = 8'h76;
    localparam logic [7:0] DIAG_BITS_VALUE   = 8'h08;
    localparam logic [7:0] CHAN_COUNT_VALUE  = 8'h04;
    localparam logic [7:0] BYTE_ZERO         = 8'h00;

    // Channel fault detail layout.
    localparam int         BIT_PARAM_FAULT   = 0;
    localparam int         BIT_SHORT_FAULT   = 3;
    localparam logic [7:0] DETAIL_USED_MASK  = 8'h09;
    localparam logic [7:0] SUMMARY_USED_MASK = 8'h0F;
    localparam logic [31:0] STAMP_RESET      = 32'h0000_0000;

endpackage : aodiag_pkg

// ---- tb/aodiag_host.sv ----
// Head station model that reads record bytes over the read port.
`timescale 1ns/1ns
module aodiag_host
    import aodiag_pkg::*;
(
    // Clock.
    input  wire logic                 i_clock,
    // Read port toward the record.
    output logic                      o_rd_en,
    output logic      [REC_IDX_W-1:0] o_rd_index,
    input  wire logic [7:0]           i_rd_data,
    input  wire logic                 i_rd_valid
);
    initial begin
        o_rd_en    = 1'b0;
        o_rd_index = '0;
    end

    // The index is inverted on release so a stale index can never pass for a held one.
    task automatic read_byte(input logic [REC_IDX_W-1:0] idx, output logic [8:0] got);
        @(posedge i_clock);
        #1;
        o_rd_en    = 1'b1;
        o_rd_index = idx;
        @(posedge i_clock);
        #1;
        got        = {i_rd_valid, i_rd_data};
        o_rd_en    = 1'b0;
        o_rd_index = ~idx;
    endtask : read_byte
endmodule : aodiag_host

// ---- tb/analog_output_diag_record_bench.sv ----
// Self-checking bench for the analog output diagnostic record.
`timescale 1ns/1ns
module analog_output_diag_record_bench
    import aodiag_pkg::*;
;
    logic                 i_clock;
    logic                 i_rst_n;
    logic [3:0]           pf;
    logic [3:0]           sd;
    logic [3:0]           se;
    logic                 rd_en;
    logic [REC_IDX_W-1:0] rd_index;
    logic [7:0]           rd_data;
    logic                 rd_valid;
    logic [3:0]           led;
    logic [31:0]          s1;
    logic [31:0]          s2;
    int                   n_errors;
    int                   n_compared;
    int                   cyc;

    aodiag_record i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_param_fault(pf), .i_short_detect(sd),
        .i_short_enable(se), .i_rd_en(rd_en), .i_rd_index(rd_index), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_channel_led(led));
    aodiag_host i_host (.i_clock(i_clock), .o_rd_en(rd_en), .o_rd_index(rd_index), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid));

    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    always @(posedge i_clock) cyc <= i_rst_n ? cyc + 1 : 0;

    function automatic logic [7:0] detail(input int ch);
        return {4'h0, sd[ch] & se[ch], 2'b00, pf[ch]};
    endfunction : detail

    function automatic logic [3:0] summ();
        logic [3:0] s;
        for (int c = 0; c < 4; c++) s[c] = |detail(c);
        return s;
    endfunction : summ

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic rd(input logic [REC_IDX_W-1:0] idx, input logic [7:0] want);
        logic [8:0] got;
        i_host.read_byte(idx, got);
        check({23'h0, got}, {24'h1, want});
    endtask : rd

    task automatic stamp_near(input int t, output logic [31:0] s);
        logic [8:0] got;
        for (int k = 0; k < 4; k++) begin
            i_host.read_byte(IDX_STAMP0 + 5'(k), got);
            s[8*k +: 8] = got[7:0];
        end
        check(s, 32'(t / TICK_CYCLES));
    endtask : stamp_near

    task automatic stop_test();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        #100000;
        n_errors++;
        stop_test();
    end

    initial begin
        int t;
        {pf, sd, se} = 12'h000;
        i_rst_n = 1'b0;
        n_errors = 0;
        n_compared = 0;
        void'($urandom(71));
        repeat (2) @(posedge i_clock);
        #1 i_rst_n = 1'b1;
        rd(IDX_KIND, KIND_ANALOG_OUT);
        rd(IDX_BITS, DIAG_BITS_VALUE);
        rd(IDX_COUNT, CHAN_COUNT_VALUE);
        for (int k = 0; k < 32; k++) begin
            if (k < 4 || (k >= 12 && k < 16) || k >= 20) rd(5'(k), BYTE_ZERO);
        end
        // The first two passes show short detection with enables off, then on.
        for (int i = 0; i < 40; i++) begin
            @(posedge i_clock);
            #1;
            {pf, sd, se} = (i == 0) ? 12'h0F0 : (i == 1) ? 12'h0FF : 12'($urandom);
            repeat (2) @(posedge i_clock);
            #1;
            check({28'h0, led}, {28'h0, summ()});
            rd(IDX_SUMMARY, {4'h0, summ()});
            for (int c = 0; c < 4; c++) rd(IDX_CH0 + 5'(c), detail(c));
        end
        {pf, sd, se} = 12'h000;
        repeat (300) @(posedge i_clock);
        #1;
        pf = 4'h4;
        t = cyc;
        repeat (3) @(posedge i_clock);
        stamp_near(t, s1);
        repeat (250) @(posedge i_clock);
        // A fault that persists keeps its stamp; a newly appearing one takes a fresh stamp.
        stamp_near(t, s2);
        check(s2, s1);
        pf = 4'h6;
        t = cyc;
        repeat (3) @(posedge i_clock);
        stamp_near(t, s2);
        stop_test();
    end
endmodule : analog_output_diag_record_bench
